// ==== slm_defines.vh ====
// Purpose: constants for the spindle load meter scaling block
// Assumes: 250 MHz processing clock
// Notes:   definitions only
`ifndef SLM_DEFINES_VH
`define SLM_DEFINES_VH

// ****************************************************************
// base selection codes
// ****************************************************************
`define SLM_BASE_MAX120     2'h0
`define SLM_BASE_MAX100     2'h1
`define SLM_BASE_SHORT      2'h2
`define SLM_BASE_CONT       2'h3
`define SLM_BASE_RESET      2'h0

// ****************************************************************
// scaling, in units of 0.1 percent
// ****************************************************************
`define SLM_SCALE_120       11'h4B0
`define SLM_SCALE_100       11'h3E8

// ****************************************************************
// filter time constant, 1 ms steps
// ****************************************************************
`define SLM_TC_MAX          13'h1388
`define SLM_TC_DEFAULT      13'h0064
`define SLM_FRAC_BITS       8

// ****************************************************************
// monitor channel
// ****************************************************************
`define SLM_MON_CODE        8'h3E

// ****************************************************************
// timing
// ****************************************************************
`define SLM_CLK_PERIOD_NS   4
`define SLM_STEP_NS         1000000
`define SLM_STEP_CYCLES     (`SLM_STEP_NS / `SLM_CLK_PERIOD_NS)
`define SLM_DIV_STEPS       6'h20

`endif

// ==== slm_load_meter.v ====
// Purpose: scales spindle motor output to a load meter and smooths it
// Assumes: all inputs synchronous to clk_i; reference inputs nonzero
// Notes:   one update per 1 ms processing step, shared serial divider
//          base code is taken once after restart; time constant is live
//          one divider serves both passes, trading 64 cycles for area
//
// Functional notes
// - base code 0 scales maximum motor output to read 120 percent.
// - base code 1 scales maximum motor output to read 100 percent.
// - base code 2 uses short-term rated output (50% duty) as 100 percent.
// - base code 3 uses continuous rated output as 100 percent.
// - reference follows the currently selected low- or high-speed winding.
// - filter time constant 0..5000 in 1 ms steps, applies immediately.
// - time constant zero bypasses filter, output equals raw value.
// - meter appears on optional monitor one when its code selects meter.
`timescale 1ns/1ps
`default_nettype none
`include "slm_defines.vh"

module slm_load_meter #(
    parameter PWR_W       = 16,
    parameter STEP_CYCLES = `SLM_STEP_CYCLES
) (
    // clock and reset
    input  wire               clk_i,
    input  wire               reset_n_i,
    // motor output and references
    input  wire [PWR_W-1:0]   motor_power_i,
    input  wire               winding_high_i,
    input  wire [PWR_W-1:0]   max_out_low_i,
    input  wire [PWR_W-1:0]   max_out_high_i,
    input  wire [PWR_W-1:0]   short_out_low_i,
    input  wire [PWR_W-1:0]   short_out_high_i,
    input  wire [PWR_W-1:0]   cont_out_low_i,
    input  wire [PWR_W-1:0]   cont_out_high_i,
    // settings
    input  wire [1:0]         load_meter_base_select_i,
    input  wire [12:0]        load_meter_filter_time_constant_i,
    input  wire [7:0]         optional_monitor_one_select_i,
    // results
    output reg  [15:0]        load_meter_o,
    output reg  [15:0]        monitor_one_o,
    output reg                meter_update_o
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RAW  = 2'h1;
    localparam [1:0] ST_FILT = 2'h2;

    // ****************************************************************
    // step timing
    // ****************************************************************
    // the step counter is 18 bits, enough for 1 ms at the 250 MHz clock
    localparam [31:0] STEP_LAST_W = STEP_CYCLES - 1;
    localparam [17:0] STEP_LAST   = STEP_LAST_W[17:0];

    reg  [1:0]  state_r;
    reg  [17:0] step_cnt_r;
    reg  [1:0]  base_r;
    reg         base_taken_r;
    reg  [31:0] div_rem_r;
    reg  [31:0] div_quo_r;
    reg  [31:0] div_den_r;
    reg  [5:0]  div_cnt_r;
    reg  [23:0] filt_r;
    reg         diff_neg_r;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // saturate rather than wrap, so an overload reads full scale
    function [15:0] sat16;
        input [31:0] v;
        begin
            sat16 = (v[31:16] != 16'h0000) ? 16'hFFFF : v[15:0];
        end
    endfunction

    // a zero reference would give an all-ones quotient; read it as one
    function [31:0] nz;
        input [31:0] v;
        begin
            nz = (v == 32'h0000_0000) ? 32'h0000_0001 : v;
        end
    endfunction

    // ****************************************************************
    // reference and scale selection
    // ****************************************************************
    reg [PWR_W-1:0] ref_pwr;
    reg [10:0]      scale;
    always @* begin
        scale = `SLM_SCALE_100;
        case (base_r)
            `SLM_BASE_MAX120: begin
                scale   = `SLM_SCALE_120;
                ref_pwr = winding_high_i ? max_out_high_i : max_out_low_i;
            end
            `SLM_BASE_MAX100: begin
                ref_pwr = winding_high_i ? max_out_high_i : max_out_low_i;
            end
            `SLM_BASE_SHORT: begin
                ref_pwr = winding_high_i ? short_out_high_i : short_out_low_i;
            end
            default: begin
                ref_pwr = winding_high_i ? cont_out_high_i : cont_out_low_i;
            end
        endcase
    end

    // product fits 32 bits while PWR_W plus the 11-bit scale stays within 32
    wire [31:0] raw_num = {{(32-PWR_W){1'b0}}, motor_power_i} * {21'h000000, scale};
    wire [31:0] ref_den = {{(32-PWR_W){1'b0}}, ref_pwr};

    // settings above the range are held at the top of the range
    wire [12:0] tc = (load_meter_filter_time_constant_i > `SLM_TC_MAX) ?
                     `SLM_TC_MAX : load_meter_filter_time_constant_i;

    // ****************************************************************
    // serial divider step
    // ****************************************************************
    // restoring divide, one quotient bit per clock
    wire [32:0] div_trial = {div_rem_r, div_quo_r[31]} - {1'b0, div_den_r};
    wire        div_fit   = ~div_trial[32];
    wire [31:0] div_rem_n = div_fit ? div_trial[31:0] : {div_rem_r[30:0], div_quo_r[31]};
    wire [31:0] div_quo_n = {div_quo_r[30:0], div_fit};
    wire        div_last  = (div_cnt_r == `SLM_DIV_STEPS - 6'h01);

    wire [15:0] raw_val   = sat16(div_quo_n);
    wire [23:0] raw_fix   = {raw_val, 8'h00};
    wire        raw_below = raw_fix < filt_r;
    wire [23:0] diff_mag  = raw_below ? (filt_r - raw_fix) : (raw_fix - filt_r);
    wire [23:0] filt_step = div_quo_n[23:0];
    // no underflow: the step never exceeds the error it was divided from
    wire [23:0] filt_nxt  = diff_neg_r ? (filt_r - filt_step) : (filt_r + filt_step);

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r        <= ST_IDLE;
            step_cnt_r     <= 18'h00000;
            base_r         <= `SLM_BASE_RESET;
            base_taken_r   <= 1'b0;
            div_rem_r      <= 32'h0000_0000;
            div_quo_r      <= 32'h0000_0000;
            div_den_r      <= 32'h0000_0001;
            div_cnt_r      <= 6'h00;
            filt_r         <= 24'h000000;
            diff_neg_r     <= 1'b0;
            load_meter_o   <= 16'h0000;
            monitor_one_o  <= 16'h0000;
            meter_update_o <= 1'b0;
        end else begin
            meter_update_o <= 1'b0;
            // base selection is only taken once after restart
            if (!base_taken_r) begin
                base_r       <= load_meter_base_select_i;
                base_taken_r <= 1'b1;
            end
            // free-running step counter; a new step starts at its wrap
            step_cnt_r <= (step_cnt_r == STEP_LAST) ? 18'h00000 : step_cnt_r + 18'h00001;
            // registered copy: the monitor trails the meter by one cycle
            monitor_one_o <= (optional_monitor_one_select_i == `SLM_MON_CODE) ?
                             load_meter_o : 16'h0000;
            case (state_r)
                ST_IDLE: begin
                    // motor output and reference are sampled only at the start edge of a step
                    if (step_cnt_r == STEP_LAST && base_taken_r) begin
                        div_rem_r <= 32'h0000_0000;
                        div_quo_r <= raw_num;
                        div_den_r <= nz(ref_den);
                        div_cnt_r <= 6'h00;
                        state_r   <= ST_RAW;
                    end
                end
                ST_RAW: begin
                    div_rem_r <= div_rem_n;
                    div_quo_r <= div_quo_n;
                    div_cnt_r <= div_cnt_r + 6'h01;
                    if (div_last) begin
                        // tc is read here, so a new setting applies from this step
                        if (tc == 13'h0000) begin
                            filt_r         <= raw_fix;
                            load_meter_o   <= raw_val;
                            meter_update_o <= 1'b1;
                            state_r        <= ST_IDLE;
                        end else begin
                            // y += (x - y) / tc, sign kept apart
                            diff_neg_r <= raw_below;
                            div_rem_r  <= 32'h0000_0000;
                            div_quo_r  <= {8'h00, diff_mag};
                            div_den_r  <= {19'h00000, tc};
                            div_cnt_r  <= 6'h00;
                            state_r    <= ST_FILT;
                        end
                    end
                end
                ST_FILT: begin
                    // second pass: divide the error by the time constant
                    div_rem_r <= div_rem_n;
                    div_quo_r <= div_quo_n;
                    div_cnt_r <= div_cnt_r + 6'h01;
                    if (div_last) begin
                        filt_r         <= filt_nxt;
                        load_meter_o   <= filt_nxt[23:8];
                        meter_update_o <= 1'b1;
                        state_r        <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // slm_load_meter
`default_nettype wire

// ==== slm_checker.sv ====
// Purpose: port assertions for the load meter block
// Assumes: STEP_CYCLES above 70, base and tc set before reset release
// Notes:   phase counter restarts at every reset release
`timescale 1ns/1ps
`default_nettype none
module slm_checker #(parameter STEP_CYCLES = 100) (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic [12:0] load_meter_filter_time_constant_i,
    input wire logic [7:0]  optional_monitor_one_select_i,
    input wire logic [15:0] load_meter_o,
    input wire logic [15:0] monitor_one_o,
    input wire logic        meter_update_o
);
    int ph_r;
    bit first_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ph_r    <= 0;
            first_r <= 1'b1;
        end else begin
            ph_r    <= (ph_r == STEP_CYCLES - 1) ? 0 : ph_r + 1;
            first_r <= first_r && (ph_r != STEP_CYCLES - 1);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_reset_zero: assert property (disable iff (1'b0) !reset_n_i |-> load_meter_o == 16'h0
        && monitor_one_o == 16'h0 && !meter_update_o) else $error("outputs not clear in reset");
    a_quiet_first: assert property (first_r |-> !meter_update_o && load_meter_o == 16'h0)
        else $error("meter moved before the first step");
    a_update_pulse: assert property ($rose(meter_update_o) |=> $fell(meter_update_o))
        else $error("update pulse longer than one cycle");
    a_update_gap: assert property (meter_update_o |=> !meter_update_o [*8])
        else $error("second update inside one step");
    a_meter_hold: assert property ($changed(load_meter_o) |-> meter_update_o)
        else $error("meter changed without update");
    a_bypass_time: assert property (!first_r && ph_r == 32
        && $past(load_meter_filter_time_constant_i) == 13'h0 |-> meter_update_o)
        else $error("unfiltered answer missing at its cycle");
    a_monitor_follow: assert property (meter_update_o && optional_monitor_one_select_i == 8'h3E
        |=> monitor_one_o == load_meter_o) else $error("monitor does not follow meter");
    a_monitor_zero: assert property (meter_update_o && optional_monitor_one_select_i != 8'h3E
        |=> monitor_one_o == 16'h0) else $error("monitor shows meter when not selected");
    c_bypass: cover property (meter_update_o && load_meter_filter_time_constant_i == 13'h0);
    c_filter: cover property (meter_update_o && load_meter_filter_time_constant_i != 13'h0);
    c_unsel: cover property (meter_update_o && optional_monitor_one_select_i != 8'h3E);
endmodule // slm_checker
bind slm_load_meter slm_checker #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .load_meter_filter_time_constant_i(load_meter_filter_time_constant_i),
    .optional_monitor_one_select_i(optional_monitor_one_select_i), .load_meter_o(load_meter_o),
    .monitor_one_o(monitor_one_o), .meter_update_o(meter_update_o));
`default_nettype wire

// ==== slm_host_model.sv ====
// Purpose: host controller that reads the monitor channel
// Assumes: monitor settles one cycle after the update pulse
// Notes:   shows the last value read, like a display
`timescale 1ns/1ps
`default_nettype none
module slm_host_model (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        meter_update_i,
    input wire logic [15:0] monitor_one_i,
    output var logic [15:0] shown_o
);
    logic upd_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            upd_r   <= 1'b0;
            shown_o <= 16'h0;
        end else begin
            upd_r <= meter_update_i;
            // read a cycle late so the registered monitor has caught up
            if (upd_r) shown_o <= monitor_one_i;
        end
    end
endmodule // slm_host_model
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the load meter block
// Assumes: short step of 100 cycles in place of 1 ms
// Notes:   base code is only taken at reset, so each base gets a reset
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int STEP = 100;
    // clock starts high, so reset falls at the first falling edge, before any rising one
    logic clk_i = 1'b1, reset_n_i = 1'b1, wh = 1'b0;
    logic [1:0] base = 2'h0;
    logic [12:0] tc = 13'h0;
    logic [7:0] sel = 8'h3E;
    logic [15:0] pw = 16'h0104, ml = 16'h0172, sl = 16'h00DC, cl = 16'h00B9, ch = 16'h0064;
    wire [15:0] meter, mon, shown;
    wire upd;
    int mismatches = 0, tests_run = 0, refs[4];
    always #2 clk_i = ~clk_i;
    slm_load_meter #(.PWR_W(16), .STEP_CYCLES(STEP)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .motor_power_i(pw), .winding_high_i(wh), .max_out_low_i(ml), .max_out_high_i(16'h0200),
        .short_out_low_i(sl), .short_out_high_i(16'h0180), .cont_out_low_i(cl),
        .cont_out_high_i(ch), .load_meter_base_select_i(base),
        .load_meter_filter_time_constant_i(tc), .optional_monitor_one_select_i(sel),
        .load_meter_o(meter), .monitor_one_o(mon), .meter_update_o(upd));
    slm_host_model host (.clk_i(clk_i), .reset_n_i(reset_n_i), .meter_update_i(upd),
        .monitor_one_i(mon), .shown_o(shown));
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task rst(input logic [1:0] b);
        reset_n_i = 1'b0;
        base = b;
        repeat (3) @(negedge clk_i);
        reset_n_i = 1'b1;
    endtask
    // sampled at the falling edge, where the one-cycle pulse is settled
    task wait_upd;
        int i;
        // step past a pulse that is still high from the previous call
        @(negedge clk_i);
        for (i = 0; i < 3 * STEP && upd !== 1'b1; i++) @(negedge clk_i);
        chk("update", 1'b1, upd);
    endtask
    task t_bases;
        int b;
        refs = '{370, 370, 220, 185};
        for (b = 0; b < 4; b++) begin
            rst(b[1:0]);
            wait_upd;
            chk("meter", 16'(260 * (b == 0 ? 1200 : 1000) / refs[b]), meter);
        end
        wh = 1'b1;
        wait_upd;
        chk("winding", 16'(260 * 1000 / 100), meter);
        repeat (3) @(negedge clk_i);
        chk("shown", 16'(2600), shown);
        sel = 8'h10;
        wait_upd;
        repeat (3) @(negedge clk_i);
        chk("unselected", 16'h0, shown);
        rst(2'h0);
        wait_upd;
        chk("winding max", 16'(260 * 1200 / 512), meter);
    endtask
    task t_filter;
        wh = 1'b0;
        ml = 16'h0208;
        tc = 13'h0002;
        rst(2'h1);
        wait_upd;
        chk("filter1", 16'(250), meter);
        wait_upd;
        chk("filter2", 16'(375), meter);
        tc = 13'h0;
        wait_upd;
        chk("bypass", 16'(500), meter);
    endtask
    initial begin
        @(negedge clk_i);
        t_bases;
        t_filter;
        test_done;
    end
    initial begin
        #(4 * STEP * 40);
        mismatches++;
        test_done;
    end
endmodule // tb
`default_nettype wire
